//--- sch_pkg.sv
// constants shared by the signaling change handler files
package sch_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int FRAME_US = 125;
  localparam int UNIT_US = 250;
  localparam int FRAME_CYC = (CLK_HZ / 1_000_000) * FRAME_US;
  localparam int UNIT_CYC = (CLK_HZ / 1_000_000) * UNIT_US;
  localparam int NPAIR = 64;
  localparam int ADDR_W = 7;
  localparam int QDEPTH = 9;
  localparam logic [3:0] ADR_QUEUE = 4'h0;
  localparam logic [3:0] ADR_TIMER = 4'h1;
  localparam logic [3:0] ADR_CMD = 4'h2;
  localparam logic [3:0] ADR_STATE = 4'h3;
  localparam logic [3:0] ADR_IRQ = 4'h4;
  localparam logic [3:0] ADR_MASK = 4'h5;
  localparam logic [3:0] ADR_MODE = 4'h6;
  localparam logic [3:0] ADR_MDATA = 4'h7;
  localparam logic [3:0] ADR_MADDR = 4'h8;
  localparam logic [3:0] ADR_MCMD = 4'h9;
  localparam int TS_FIXED_BIT = 7;
  localparam int CMD_FLUSH_BIT = 0;
  localparam int CMD_GO_BIT = 1;
  localparam int ST_MAC_BIT = 7;
  localparam int ST_TIMER_BIT = 6;
  localparam logic [7:0] ST_RESET = 8'h05;
  localparam int IRQ_CHG_BIT = 6;
  localparam int Q_VALID_BIT = 7;
  localparam int MA_UP_BIT = 7;
  localparam int MC_RWS_BIT = 7;
  localparam logic [2:0] MOC_CODE_DATA = 3'h7;
  localparam logic [3:0] MOC_DATA = 4'h9;
  localparam logic [3:0] CODE_CI = 4'h8;
  localparam logic [3:0] CODE_SIG = 4'ha;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage

//--- sch_fifo_if.sv
// link between the handler and its change address queue
`timescale 1ns/100ps
`default_nettype none
interface sch_fifo_if;
  logic push;
  logic pop;
  logic flush;
  logic [6:0] wr_addr;
  logic [6:0] head;
  logic full;
  logic empty;
  modport fifo (input push, pop, flush, wr_addr, output head, full, empty);
  modport user (output push, pop, flush, wr_addr, input head, full, empty);
endinterface
`default_nettype wire

//--- sch_addr_fifo.sv
// nine entry queue of changed control memory addresses
`timescale 1ns/100ps
`default_nettype none
module sch_addr_fifo
  import sch_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  sch_fifo_if.fifo q
);
  logic [ADDR_W-1:0] mem_q [QDEPTH];
  logic [3:0] wr_q;
  logic [3:0] rd_q;
  logic [3:0] cnt_q;
  wire do_push = q.push && !q.full;
  wire do_pop = q.pop && !q.empty;
  wire [3:0] wr_inc = (wr_q == 4'(QDEPTH - 1)) ? 4'h0 : wr_q + 4'h1;
  wire [3:0] rd_inc = (rd_q == 4'(QDEPTH - 1)) ? 4'h0 : rd_q + 4'h1;

  assign q.full = (cnt_q == 4'(QDEPTH));
  assign q.empty = (cnt_q == 4'h0);
  assign q.head = mem_q[rd_q];

  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= q.wr_addr;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || q.flush) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      if (do_push) begin
        wr_q <= wr_inc;
      end
      if (do_pop) begin
        rd_q <= rd_inc;
      end
      cnt_q <= cnt_q + 4'(do_push) - 4'(do_pop);
    end
  end
endmodule // sch_addr_fifo
`default_nettype wire

//--- sch_signaling_handler.sv
// command/indication and signaling change handler with control memory
//
// Summary of operation
// - downstream value in control memory is resent every frame until replaced
// - detected upstream change pushes its address to queue and flags interrupt
// - with nine unread entries, further changes are not written to memory
// - pending changes are written one by one as queue space frees
// - queue word: valid flag bit 7, address bits 6 to 0
// - queue address is even for command/indication, odd for signaling
// - fixed rate bit set gives 125 us last-look period
// - fixed rate clear gives (1 + reload) times 250 us period
// - timer starts on go command, stops on timer write or mode bit clear
// - timer tick and last-look share one timer period; frame sync runs from its own frame counter
// - flush command clears queue and change flag on the next clock
// - state register is current state only, reset value 05 hex
// - timer running bit reads one while the timer runs
// - change flag is one while queue holds entries; reads do not clear
// - mask bit gates only the interrupt pin, never the flag
// - code 111X write copies channel code and data into memory
// - code 1001 write copies only data, code field untouched
// - timer paces only signaling channels; command/indication sampled per frame
// - command/indication value sampled every frame, kept at even address
// - stable value updates on two equal samples differing from it
// - latest sample at even address, stable value at odd address
`timescale 1ns/100ps
`default_nettype none
module sch_signaling_handler
  import sch_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  output logic [5:0] slot_out,
  output logic slot_valid_out,
  output logic [7:0] ds_value_out,
  input wire logic [7:0] us_value_in,
  output logic timer_tick_out
);
  sch_fifo_if qif ();

  sch_addr_fifo u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .q(qif.fifo)
  );

  // control memories, code and data field per location
  logic [7:0] ds_data_q [2**ADDR_W];
  logic [3:0] ds_code_q [2**ADDR_W];
  logic [7:0] us_data_q [2**ADDR_W];
  logic [3:0] us_code_q [2**ADDR_W];

  logic [7:0] timer_q;
  logic [7:0] mask_q;
  logic [7:0] mode_q;
  logic [7:0] mdata_q;
  logic [7:0] maddr_q;
  logic [7:0] mcmd_q;
  logic mac_busy_q;
  logic run_q;
  logic [11:0] pre_q;
  logic [6:0] unit_q;
  logic ll_pend_q;
  logic ll_go_q;
  logic [10:0] frame_q;
  logic [7:0] us_meta_q;
  logic [7:0] us_sync_q;
  logic [5:0] idx1_q;
  logic [5:0] idx2_q;
  logic vld1_q;
  logic vld2_q;
  logic [7:0] rdata_q;

  // register decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  wire wr_timer = wr_in && hit(addr_in, ADR_TIMER);
  wire wr_cmd = wr_in && hit(addr_in, ADR_CMD);
  wire wr_mcmd = wr_in && hit(addr_in, ADR_MCMD);
  wire rd_queue = rd_in && hit(addr_in, ADR_QUEUE);
  wire cmd_go = wr_cmd && wdata_in[CMD_GO_BIT];
  wire cmd_flush = wr_cmd && wdata_in[CMD_FLUSH_BIT];
  wire fixed_rate = timer_q[TS_FIXED_BIT];
  wire [6:0] reload = timer_q[6:0];

  // frame pacing: one scan of all slot pairs at the head of each frame
  wire frame_end = (frame_q == 11'(FRAME_CYC - 1));
  wire frame_start = (frame_q == 11'h000);
  wire scan = (frame_q < 11'(NPAIR));
  // pairs without a channel code send the idle all-ones value
  wire [6:0] ds_adr = {frame_q[5:0], 1'b0};
  wire ds_cs = (ds_code_q[ds_adr] == CODE_CI) || (ds_code_q[ds_adr] == CODE_SIG);

  // timer in 250 us units; stopped while mode bit 0 is low
  wire unit_end = run_q && (pre_q == 12'(UNIT_CYC - 1));
  wire timer_exp = unit_end && (unit_q == reload);
  wire timer_stop = wr_timer || !mode_q[0];

  // upstream processing stage, aligned with the synchronised sample
  wire [6:0] addr_e = {idx2_q, 1'b0};
  wire [6:0] addr_o = {idx2_q, 1'b1};
  wire [3:0] code_e = us_code_q[addr_e];
  wire [7:0] act_v = us_data_q[addr_e];
  wire [7:0] stab_v = us_data_q[addr_o];
  wire is_ci = vld2_q && (code_e == CODE_CI);
  wire sig_on = vld2_q && (code_e == CODE_SIG) && ll_go_q;
  wire ci_chg = is_ci && (us_sync_q != act_v);
  wire sig_chg = sig_on && (us_sync_q == act_v) && (us_sync_q != stab_v);
  // full queue freezes the pair so the change is seen again later
  wire room = !qif.full;
  wire act_we = room && (ci_chg || sig_on);
  wire stab_we = room && sig_chg;

  // processor memory access runs only when the scan stage is idle
  wire mac_go = mac_busy_q && !vld2_q;
  wire m_up = maddr_q[MA_UP_BIT];
  wire [6:0] m_adr = maddr_q[6:0];
  wire m_rws = mcmd_q[MC_RWS_BIT];
  wire op_cd = mac_go && !m_rws && (mcmd_q[6:4] == MOC_CODE_DATA);
  wire op_dw = mac_go && !m_rws && (mcmd_q[6:3] == MOC_DATA);
  wire op_dr = mac_go && m_rws && (mcmd_q[6:3] == MOC_DATA);
  wire [7:0] m_rd = m_up ? us_data_q[m_adr] : ds_data_q[m_adr];

  wire chg_flag = !qif.empty;
  wire [7:0] state_w = ST_RESET | {mac_busy_q, run_q, 6'h00};
  wire [7:0] irq_w = {1'b0, chg_flag, 6'h00};
  wire [7:0] queue_w = qif.empty ? 8'h00 : {1'b1, qif.head};

  assign qif.push = ci_chg ? act_we : stab_we;
  assign qif.wr_addr = ci_chg ? addr_e : addr_o;
  assign qif.pop = rd_queue;
  assign qif.flush = cmd_flush;

  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    unique case (addr_in)
      ADR_QUEUE: rsel = queue_w;
      ADR_STATE: rsel = state_w;
      ADR_IRQ: rsel = irq_w;
      ADR_MASK: rsel = mask_q;
      ADR_MODE: rsel = mode_q;
      ADR_MDATA: rsel = mdata_q;
      ADR_MADDR: rsel = maddr_q;
      ADR_MCMD: rsel = mcmd_q;
      default: rsel = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_in ? rsel : 8'h00;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      timer_q <= REG_RESET;
      mask_q <= REG_RESET;
      mode_q <= REG_RESET;
      maddr_q <= REG_RESET;
      mcmd_q <= REG_RESET;
    end else if (wr_in) begin
      if (wr_timer) timer_q <= wdata_in;
      if (hit(addr_in, ADR_MASK)) mask_q <= wdata_in;
      if (hit(addr_in, ADR_MODE)) mode_q <= wdata_in;
      if (hit(addr_in, ADR_MADDR)) maddr_q <= wdata_in;
      if (wr_mcmd) mcmd_q <= wdata_in;
    end
  end

  // data register takes read-back data over a processor write
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mdata_q <= REG_RESET;
      mac_busy_q <= 1'b0;
    end else begin
      if (op_dr) begin
        mdata_q <= m_rd;
      end else if (wr_in && hit(addr_in, ADR_MDATA)) begin
        mdata_q <= wdata_in;
      end
      mac_busy_q <= wr_mcmd || (mac_busy_q && !mac_go);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
      pre_q <= 12'h000;
      unit_q <= 7'h00;
    end else if (timer_stop) begin
      run_q <= 1'b0;
      pre_q <= 12'h000;
      unit_q <= 7'h00;
    end else if (cmd_go) begin
      run_q <= 1'b1;
      pre_q <= 12'h000;
      unit_q <= 7'h00;
    end else if (run_q) begin
      pre_q <= unit_end ? 12'h000 : pre_q + 12'h001;
      if (timer_exp) begin
        unit_q <= 7'h00;
      end else if (unit_end) begin
        unit_q <= unit_q + 7'h01;
      end
    end
  end

  // one timer serves tick output and last-look pacing alike
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      timer_tick_out <= 1'b0;
      ll_pend_q <= 1'b0;
      ll_go_q <= 1'b0;
    end else begin
      timer_tick_out <= timer_exp;
      ll_pend_q <= timer_exp || (ll_pend_q && !frame_start);
      if (frame_start) begin
        ll_go_q <= fixed_rate || ll_pend_q || timer_exp;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      frame_q <= 11'h000;
      slot_out <= 6'h00;
      slot_valid_out <= 1'b0;
      ds_value_out <= 8'hff;
    end else begin
      frame_q <= frame_end ? 11'h000 : frame_q + 11'h001;
      slot_valid_out <= scan;
      if (scan) begin
        slot_out <= frame_q[5:0];
        ds_value_out <= ds_cs ? ds_data_q[ds_adr] : 8'hff;
      end
    end
  end

  // upstream pins cross in from the line side through two flops
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      us_meta_q <= 8'hff;
      us_sync_q <= 8'hff;
      idx1_q <= 6'h00;
      idx2_q <= 6'h00;
      vld1_q <= 1'b0;
      vld2_q <= 1'b0;
    end else begin
      us_meta_q <= us_value_in;
      us_sync_q <= us_meta_q;
      idx1_q <= slot_out;
      idx2_q <= idx1_q;
      vld1_q <= slot_valid_out;
      vld2_q <= vld1_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (act_we) begin
      us_data_q[addr_e] <= us_sync_q;
    end
    if (stab_we) begin
      us_data_q[addr_o] <= us_sync_q;
    end
    if ((op_cd || op_dw) && m_up) begin
      us_data_q[m_adr] <= mdata_q;
    end
    if ((op_cd || op_dw) && !m_up) begin
      ds_data_q[m_adr] <= mdata_q;
    end
  end

  // code fields start cleared so unprogrammed pairs never reach the queue
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        us_code_q[i] <= 4'h0;
        ds_code_q[i] <= 4'h0;
      end
    end else begin
      if (op_cd && m_up) begin
        us_code_q[m_adr] <= mcmd_q[3:0];
      end
      if (op_cd && !m_up) begin
        ds_code_q[m_adr] <= mcmd_q[3:0];
      end
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out = chg_flag && !mask_q[IRQ_CHG_BIT];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_flush;
    cmd_flush |=> qif.empty && !irq_w[IRQ_CHG_BIT];
  endproperty
  a_flush: assert property (p_flush) else $error("flush left queue or flag set");

  property p_flag;
    (rd_in && hit(addr_in, ADR_IRQ)) |=>
      (rdata_out[IRQ_CHG_BIT] == $past(chg_flag)) && (chg_flag || !$past(chg_flag));
  endproperty
  a_flag: assert property (p_flag) else $error("change flag read wrong or cleared by read");

  property p_mask;
    (chg_flag && mask_q[IRQ_CHG_BIT]) |-> !irq_out && irq_w[IRQ_CHG_BIT];
  endproperty
  a_mask: assert property (p_mask) else $error("mask touched flag or pin leaked");

  property p_start;
    (cmd_go && !timer_stop) |=> run_q && state_w[ST_TIMER_BIT];
  endproperty
  a_start: assert property (p_start) else $error("timer did not start");

  property p_stop;
    wr_timer |=> !state_w[ST_TIMER_BIT];
  endproperty
  a_stop: assert property (p_stop) else $error("timer write did not stop timer");

  property p_full;
    qif.full |-> !act_we && !stab_we && !qif.push;
  endproperty
  a_full: assert property (p_full) else $error("memory written while queue full");

  property p_fixed;
    (frame_start && fixed_rate) |=> ll_go_q;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed rate frame not sampled");

  property p_empty_rd;
    (rd_queue && qif.empty) |=> !rdata_out[Q_VALID_BIT];
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("empty read shows valid");

  property p_valid_rd;
    (rd_queue && !qif.empty) |=> rdata_out[Q_VALID_BIT] && (rdata_out[6:0] == $past(qif.head));
  endproperty
  a_valid_rd: assert property (p_valid_rd) else $error("queue word wrong");

  property p_push;
    (qif.push && !qif.flush) |=> !qif.empty;
  endproperty
  a_push: assert property (p_push) else $error("change not queued");

  property p_state_rd;
    (rd_in && hit(addr_in, ADR_STATE) && !wr_in) |=> $stable(state_w) || $past(mac_go) || $past(run_q);
  endproperty
  a_state_rd: assert property (p_state_rd) else $error("state read changed state");
endmodule // sch_signaling_handler
`default_nettype wire

//--- sch_signaling_handler_end.sv
// intentionally empty: holds no module
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- sch_sub_model.sv
// subscriber side model: upstream values per pair, downstream capture
`timescale 1ns/100ps
`default_nettype none
module sch_sub_model (
  input wire logic ref_clk_in,
  input wire logic [5:0] slot_in,
  input wire logic slot_valid_in,
  input wire logic [7:0] ds_value_in,
  output logic [7:0] us_value_out
);
  logic [7:0] up_val [64];
  logic [7:0] dn_seen [64];
  logic [7:0] last_q = 8'h00;
  initial foreach (up_val[i]) up_val[i] = 8'hff;
  // idle line toggles so a stale value can never look valid
  assign us_value_out = slot_valid_in ? up_val[slot_in] : ~last_q;
  always @(posedge ref_clk_in) begin
    last_q <= us_value_out;
    if (slot_valid_in) dn_seen[slot_in] <= ds_value_in;
  end
endmodule // sch_sub_model
`default_nettype wire

//--- sch_signaling_handler_tb.sv
// self-checking bench for the signaling change handler
`timescale 1ns/100ps
`default_nettype none
module sch_signaling_handler_tb import sch_pkg::*;;
  localparam logic [7:0] CI_W = {1'b0, MOC_CODE_DATA, CODE_CI};
  localparam logic [7:0] SG_W = {1'b0, MOC_CODE_DATA, CODE_SIG};
  localparam logic [7:0] DAT_W = {1'b0, MOC_DATA, 3'h0};
  localparam logic [7:0] DAT_R = {1'b1, MOC_DATA, 3'h0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, ds, us, d;
  logic [5:0] slot;
  logic irq, sv, tick;
  int error_cnt = 0;
  int checked = 0;
  int n;
  initial forever #50 clk = ~clk;
  sch_signaling_handler sch_signaling_handler_inst (.ref_clk_in(clk), .reset_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_en), .rd_in(rd_en), .rdata_out(rdata), .irq_out(irq), .slot_out(slot),
    .slot_valid_out(sv), .ds_value_out(ds), .us_value_in(us), .timer_tick_out(tick));
  sch_sub_model sch_sub_model_inst (.ref_clk_in(clk), .slot_in(slot), .slot_valid_in(sv),
    .ds_value_in(ds), .us_value_out(us));
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic mem(input logic [7:0] a, input logic [7:0] v, input logic [7:0] c);
    logic [7:0] s;
    int k;
    wr(ADR_MDATA, v);
    wr(ADR_MADDR, a);
    wr(ADR_MCMD, c);
    s = 8'h80;
    // access waits for an idle scan stage, so poll with a bound
    for (k = 0; k < 60 && s[ST_MAC_BIT] !== 1'b0; k++) rd(ADR_STATE, s);
    if (s[ST_MAC_BIT] !== 1'b0) begin
      cmp("access busy", 8'h00, s);
      print_verdict();
    end
  endtask
  task automatic mrd(input logic [7:0] a, input logic [7:0] e);
    mem(a, 8'h00, DAT_R);
    rd(ADR_MDATA, d);
    cmp("memory data", e, d);
  endtask
  task automatic frames(input int k);
    repeat (k * FRAME_CYC) @(posedge clk);
  endtask
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (tick !== 1'b1 && k < 6000);
    if (k == 6000) begin
      cmp("tick", 8'h01, {7'h00, tick});
      print_verdict();
    end
  endtask
  task automatic t_reset;
    rd(ADR_STATE, d);
    cmp("state", ST_RESET, d);
    rd(ADR_STATE, d);
    cmp("state reread", ST_RESET, d);
    rd(ADR_IRQ, d);
    cmp("irq status", 8'h00, d);
    rd(ADR_QUEUE, d);
    cmp("empty queue", 8'h00, d & 8'h80);
    rd(ADR_TIMER, d);
    cmp("timer readback", 8'h00, d);
    rd(4'hf, d);
    cmp("unmapped", 8'h00, d);
  endtask
  task automatic t_down;
    mem(8'h0c, 8'hd7, CI_W);
    frames(2);
    cmp("downstream", 8'hd7, sch_sub_model_inst.dn_seen[6]);
    frames(1);
    cmp("downstream repeat", 8'hd7, sch_sub_model_inst.dn_seen[6]);
    mem(8'h0c, 8'hcf, DAT_W);
    frames(2);
    cmp("downstream data only", 8'hcf, sch_sub_model_inst.dn_seen[6]);
  endtask
  task automatic t_ci;
    mem(8'h8a, 8'hff, CI_W);
    frames(2);
    rd(ADR_IRQ, d);
    cmp("no change", 8'h00, d);
    sch_sub_model_inst.up_val[5] <= 8'hc3;
    frames(2);
    cmp("irq pin", 8'h01, {7'h00, irq});
    rd(ADR_IRQ, d);
    cmp("change flag", 8'h40, d);
    rd(ADR_QUEUE, d);
    cmp("queue word", 8'h8a, d);
    mrd(8'h8a, 8'hc3);
    rd(ADR_QUEUE, d);
    cmp("queue drained", 8'h00, d & 8'h80);
    rd(ADR_IRQ, d);
    cmp("flag clear", 8'h00, d);
  endtask
  task automatic t_mask;
    wr(ADR_MASK, 8'h40);
    sch_sub_model_inst.up_val[5] <= 8'hcf;
    frames(2);
    cmp("masked pin", 8'h00, {7'h00, irq});
    rd(ADR_IRQ, d);
    cmp("masked flag", 8'h40, d);
    wr(ADR_CMD, 8'h01);
    rd(ADR_IRQ, d);
    cmp("flushed flag", 8'h00, d);
    rd(ADR_QUEUE, d);
    cmp("flushed queue", 8'h00, d & 8'h80);
    wr(ADR_MASK, 8'h00);
  endtask
  task automatic t_full;
    for (int i = 10; i < 20; i++) mem(8'(128 + 2 * i), 8'hff, CI_W);
    frames(2);
    for (int i = 10; i < 20; i++) sch_sub_model_inst.up_val[i] <= 8'hc7;
    frames(2);
    mrd(8'ha6, 8'hff);
    for (int i = 10; i < 19; i++) begin
      rd(ADR_QUEUE, d);
      cmp("queue order", 8'(128 + 2 * i), d);
    end
    frames(2);
    rd(ADR_QUEUE, d);
    cmp("pending entry", 8'ha6, d);
    mrd(8'ha6, 8'hc7);
  endtask
  task automatic t_sig;
    wr(ADR_TIMER, 8'h80);
    // stable value first, so the pair is complete once its code goes live
    mem(8'hbd, 8'hff, SG_W);
    mem(8'hbc, 8'hff, SG_W);
    frames(2);
    sch_sub_model_inst.up_val[30] <= 8'h37;
    frames(3);
    rd(ADR_QUEUE, d);
    cmp("stable address", 8'hbd, d);
    mrd(8'hbc, 8'h37);
    mrd(8'hbd, 8'h37);
  endtask
  task automatic t_timer;
    wr(ADR_TIMER, 8'h01);
    wr(ADR_CMD, 8'h02);
    rd(ADR_STATE, d);
    cmp("timer running", 8'h45, d);
    gap(n);
    gap(n);
    cmp("timer period", 8'(UNIT_CYC * 2 / 100), 8'(n / 100));
    cmp("timer period fine", 8'(UNIT_CYC * 2 % 100), 8'(n % 100));
    wr(ADR_TIMER, 8'h01);
    rd(ADR_STATE, d);
    cmp("stop on write", ST_RESET, d);
    wr(ADR_CMD, 8'h02);
    wr(ADR_MODE, 8'h00);
    rd(ADR_STATE, d);
    cmp("stop on mode", ST_RESET, d);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    wr(ADR_MODE, 8'h01);
    t_down();
    t_ci();
    t_mask();
    t_full();
    t_sig();
    t_timer();
    print_verdict();
  end
endmodule // sch_signaling_handler_tb
`default_nettype wire
